/* File: include/fpdi_pkg.sv */
// constants for the process data image framer
package fpdi_pkg;
	localparam logic [5:0] IMG_BYTES  = 6'h28;
	localparam logic [5:0] IMG_LAST   = 6'h27;
	localparam int         IMG_W      = 320;
	localparam int         CMD_W      = 192;
	localparam logic [7:0] ASM_CMD    = 8'h67;
	localparam logic [7:0] ASM_STAT   = 8'h71;
	// byte offsets shared by both images
	localparam int OFS_SUBIDX = 0;
	localparam int OFS_CODE   = 1;
	localparam int OFS_INDEX  = 2;
	localparam int OFS_VALUE  = 4;
	// command image
	localparam int OFS_SP32   = 8;
	localparam int OFS_SP16   = 12;
	localparam int OFS_OPSEL  = 14;
	localparam int OFS_STCMD  = 15;
	localparam int OFS_ACCEL  = 16;
	localparam int OFS_DECEL  = 20;
	// status image
	localparam int OFS_CAPT   = 8;
	localparam int OFS_MOTION = 10;
	localparam int OFS_DIO    = 12;
	localparam int OFS_OPREP  = 13;
	localparam int OFS_STREP  = 14;
	localparam int OFS_POS    = 16;
	localparam int OFS_VEL    = 20;
	// bit positions
	localparam int CAPT2_BIT  = 2;
	localparam int MF_STILL   = 6;
	localparam int MF_FWD     = 7;
	localparam int MF_BWD     = 8;
	localparam int MF_WIN     = 9;
	localparam int PF_STILL   = 11;
	localparam int PF_SLOW    = 12;
	localparam int PF_SPEED   = 13;
	localparam int PF_CRUISE  = 14;
	localparam int DIO_SAFE_TORQUE_OFF_CHAN_A  = 4;
	localparam int DIO_SAFE_TORQUE_OFF_CHAN_B  = 5;
	localparam int TOGGLE_BIT = 7;
	localparam int OPREP_TOG  = 7;
	localparam int OPREP_FLT  = 6;
	localparam int OPREP_MW   = 6;
	localparam int STREP_END  = 14;
	// register map, byte addresses
	localparam logic [4:0] REG_CTRL   = 5'h00;
	localparam logic [4:0] REG_STAT   = 5'h04;
	localparam logic [4:0] REG_POLLS  = 5'h08;
	localparam logic [4:0] REG_REJECT = 5'h0c;
	localparam logic [4:0] REG_ASM    = 5'h10;
	localparam int CTRL_EN    = 0;
	localparam int CTRL_CLR   = 1;
endpackage : fpdi_pkg

/* File: rtl/fpdi_framer.sv */
// process data image framer with mode toggle handshake
module fpdi_framer (
	input  wire logic        mclk,
	input  wire logic        rst_b,
	// avalon-mm slave
	input  wire logic [4:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	// poll command byte stream
	input  wire logic        rx_valid,
	input  wire logic        rx_sof,
	input  wire logic [7:0]  rx_data,
	output logic             rx_ready,
	// poll response byte stream
	output logic             tx_valid,
	output logic      [7:0]  tx_data,
	output logic             tx_last,
	input  wire logic        tx_ready,
	// command fields toward the drive
	output logic             cmd_strobe,
	output logic      [7:0]  param_subindex,
	output logic      [7:0]  param_command_code,
	output logic      [15:0] param_index,
	output logic      [31:0] param_value,
	output logic      [31:0] setpoint32,
	output logic      [15:0] setpoint16,
	output logic      [7:0]  op_select_field,
	output logic      [7:0]  state_command_field,
	output logic      [31:0] accel_rate,
	output logic      [31:0] decel_rate,
	output logic             mode_start,
	// drive state for the status image
	input  wire logic [7:0]  rsp_subindex,
	input  wire logic [7:0]  rsp_command_code,
	input  wire logic [15:0] rsp_index,
	input  wire logic [31:0] rsp_value,
	input  wire logic [1:0]  capt1_count,
	input  wire logic [1:0]  capt2_count,
	input  wire logic        motor_still,
	input  wire logic        motor_forward,
	input  wire logic        motor_backward,
	input  wire logic        within_deviation_window,
	input  wire logic        profile_still,
	input  wire logic        profile_slowing,
	input  wire logic        profile_speeding_up,
	input  wire logic        profile_cruising,
	input  wire logic        local_input_1,
	input  wire logic        local_input_2,
	input  wire logic        local_input_3,
	input  wire logic        local_input_4,
	input  wire logic        safe_torque_off_chan_a,
	input  wire logic        safe_torque_off_chan_b,
	input  wire logic [5:0]  cur_mode,
	input  wire logic [15:0] cur_state,
	input  wire logic [31:0] actual_position,
	input  wire logic [31:0] actual_velocity,
	input  wire logic        op_enabled,
	input  wire logic        move_done
);

	typedef struct packed {
		logic [fpdi_pkg::IMG_W-1:0] rx_img;
		logic [5:0]                 rx_cnt;
		logic [fpdi_pkg::CMD_W-1:0] cmd_img;
		logic [fpdi_pkg::IMG_W-1:0] tx_img;
		logic [5:0]                 tx_cnt;
		logic                       tx_busy;
		logic                       cmd_strobe;
		logic                       mode_start;
		logic                       tog_last;
		logic                       echo;
		logic                       fault;
		logic                       running;
		logic                       move_end;
		logic                       enable;
		logic [15:0]                polls;
		logic [15:0]                rejects;
		logic                       ack;
		logic [31:0]                rdata;
	} fpdi_state_t;

	localparam fpdi_state_t ST_RST = '{
		enable:   1'b1,
		move_end: 1'b1,
		default:  '0
	};

	logic [1:0]  rst_pipe_reg;
	logic        rst_sync_b;
	fpdi_state_t state_reg;
	fpdi_state_t state_next;
	logic        rx_fire;
	logic        cmd_done;
	logic        toggled;
	logic        new_tog;
	logic        bus_acc;

	// reset release through two flops
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rst_pipe_reg <= 2'h0;
		end else begin
			rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
		end
	end
	assign rst_sync_b = rst_pipe_reg[1];

	// stall the command stream while a response drains
	assign rx_ready = !state_reg.tx_busy;
	assign rx_fire  = rx_valid && rx_ready;
	assign bus_acc  = avs_read || avs_write;

	// next state
	always_comb begin
		logic [5:0]                 cnt_n;
		logic [fpdi_pkg::IMG_W-1:0] st;
		cnt_n      = '0;
		st         = '0;
		state_next = state_reg;
		state_next.cmd_strobe = 1'b0;
		state_next.mode_start = 1'b0;
		cmd_done   = 1'b0;
		new_tog    = 1'b0;
		toggled    = 1'b0;

		// response bytes leave lowest offset first
		if (state_reg.tx_busy && tx_ready) begin
			state_next.tx_img = {8'h00,
				state_reg.tx_img[fpdi_pkg::IMG_W-1:8]};
			state_next.tx_cnt = state_reg.tx_cnt + 6'h01;
			if (state_reg.tx_cnt == fpdi_pkg::IMG_LAST) begin
				state_next.tx_busy = 1'b0;
				state_next.tx_cnt  = 6'h00;
			end
		end

		// command bytes shift in, byte 0 ends at the bottom
		if (rx_fire) begin
			cnt_n = rx_sof ? 6'h01 : state_reg.rx_cnt + 6'h01;
			state_next.rx_img = {rx_data,
				state_reg.rx_img[fpdi_pkg::IMG_W-1:8]};
			state_next.rx_cnt = cnt_n;
			if (cnt_n == fpdi_pkg::IMG_BYTES) begin
				state_next.rx_cnt = 6'h00;
				cmd_done = state_reg.enable;
			end
		end

		// movement finish raises the end flag
		if (state_reg.running && move_done) begin
			state_next.running  = 1'b0;
			state_next.move_end = 1'b1;
		end

		if (cmd_done) begin
			// only bytes 0-23 are kept, reserved tail dropped
			state_next.cmd_img =
				state_next.rx_img[fpdi_pkg::CMD_W-1:0];
			state_next.cmd_strobe = 1'b1;
			new_tog = state_next.rx_img[8*fpdi_pkg::OFS_OPSEL
				+ fpdi_pkg::TOGGLE_BIT];
			// either edge of the toggle is a request
			toggled = new_tog != state_reg.tog_last;
			if (toggled) begin
				state_next.tog_last = new_tog;
				state_next.echo     = new_tog;
				if (op_enabled) begin
					state_next.mode_start = 1'b1;
					state_next.running    = 1'b1;
					state_next.move_end   = 1'b0;
					state_next.fault      = 1'b0;
				end else begin
					state_next.fault   = 1'b1;
					state_next.rejects =
						state_reg.rejects + 16'h0001;
				end
			end
		end

		// status image, reserved bits stay zero
		st[8*fpdi_pkg::OFS_SUBIDX +: 8]  = rsp_subindex;
		st[8*fpdi_pkg::OFS_CODE +: 8]    = rsp_command_code;
		st[8*fpdi_pkg::OFS_INDEX +: 16]  = rsp_index;
		st[8*fpdi_pkg::OFS_VALUE +: 32]  = rsp_value;
		st[8*fpdi_pkg::OFS_CAPT +: 2]    = capt1_count;
		st[8*fpdi_pkg::OFS_CAPT
			+ fpdi_pkg::CAPT2_BIT +: 2]  = capt2_count;
		st[8*fpdi_pkg::OFS_MOTION + fpdi_pkg::MF_STILL] =
			motor_still;
		st[8*fpdi_pkg::OFS_MOTION + fpdi_pkg::MF_FWD] =
			motor_forward;
		st[8*fpdi_pkg::OFS_MOTION + fpdi_pkg::MF_BWD] =
			motor_backward;
		st[8*fpdi_pkg::OFS_MOTION + fpdi_pkg::MF_WIN] =
			within_deviation_window;
		st[8*fpdi_pkg::OFS_MOTION + fpdi_pkg::PF_STILL] =
			profile_still;
		st[8*fpdi_pkg::OFS_MOTION + fpdi_pkg::PF_SLOW] =
			profile_slowing;
		st[8*fpdi_pkg::OFS_MOTION + fpdi_pkg::PF_SPEED] =
			profile_speeding_up;
		st[8*fpdi_pkg::OFS_MOTION + fpdi_pkg::PF_CRUISE] =
			profile_cruising;
		st[8*fpdi_pkg::OFS_DIO +: 4] = {local_input_4,
			local_input_3, local_input_2, local_input_1};
		st[8*fpdi_pkg::OFS_DIO + fpdi_pkg::DIO_SAFE_TORQUE_OFF_CHAN_A] =
			safe_torque_off_chan_a;
		st[8*fpdi_pkg::OFS_DIO + fpdi_pkg::DIO_SAFE_TORQUE_OFF_CHAN_B] =
			safe_torque_off_chan_b;
		st[8*fpdi_pkg::OFS_OPREP +: fpdi_pkg::OPREP_MW] =
			cur_mode;
		st[8*fpdi_pkg::OFS_OPREP + fpdi_pkg::OPREP_FLT] =
			state_next.fault;
		st[8*fpdi_pkg::OFS_OPREP + fpdi_pkg::OPREP_TOG] =
			state_next.echo;
		st[8*fpdi_pkg::OFS_STREP +: 16] = cur_state;
		st[8*fpdi_pkg::OFS_STREP + fpdi_pkg::STREP_END] =
			state_next.move_end;
		st[8*fpdi_pkg::OFS_POS +: 32] = actual_position;
		st[8*fpdi_pkg::OFS_VEL +: 32] = actual_velocity;

		// every complete poll taken while enabled gets exactly one raw response
		if (cmd_done) begin
			state_next.tx_img  = st;
			state_next.tx_busy = 1'b1;
			state_next.tx_cnt  = 6'h00;
			state_next.polls   = state_reg.polls + 16'h0001;
		end

		// bus: one wait cycle, then the answer
		state_next.ack = bus_acc && !state_reg.ack;
		if (avs_read && !state_reg.ack) begin
			unique case (avs_address)
			fpdi_pkg::REG_CTRL: begin
				state_next.rdata = {31'h0, state_reg.enable};
			end
			fpdi_pkg::REG_STAT: begin
				state_next.rdata = {28'h0, state_reg.move_end,
					state_reg.echo, state_reg.fault,
					state_reg.running};
			end
			fpdi_pkg::REG_POLLS: begin
				state_next.rdata = {16'h0, state_reg.polls};
			end
			fpdi_pkg::REG_REJECT: begin
				state_next.rdata = {16'h0, state_reg.rejects};
			end
			fpdi_pkg::REG_ASM: begin
				state_next.rdata = {16'h0, fpdi_pkg::ASM_STAT,
					fpdi_pkg::ASM_CMD};
			end
			default: begin
				state_next.rdata = 32'h0;
			end
			endcase
		end
		// writes land on the edge that samples waitrequest low, one after the wait
		if (avs_write && state_reg.ack && avs_byteenable[0]
			&& avs_address == fpdi_pkg::REG_CTRL) begin
			state_next.enable =
				avs_writedata[fpdi_pkg::CTRL_EN];
			if (avs_writedata[fpdi_pkg::CTRL_CLR]) begin
				state_next.polls   = 16'h0;
				state_next.rejects = 16'h0;
			end
		end
	end

	// state register
	always_ff @(posedge mclk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			state_reg <= ST_RST;
		end else begin
			state_reg <= state_next;
		end
	end

	// outputs straight from the state, waitrequest also gated by the bus access
	assign avs_waitrequest = bus_acc && !state_reg.ack;
	assign avs_readdata    = state_reg.rdata;
	assign tx_valid        = state_reg.tx_busy;
	assign tx_data         = state_reg.tx_img[7:0];
	assign tx_last         = state_reg.tx_busy
		&& state_reg.tx_cnt == fpdi_pkg::IMG_LAST;
	assign cmd_strobe      = state_reg.cmd_strobe;
	assign mode_start      = state_reg.mode_start;

	// command fields, lowest byte first
	assign param_subindex      =
		state_reg.cmd_img[8*fpdi_pkg::OFS_SUBIDX +: 8];
	assign param_command_code  =
		state_reg.cmd_img[8*fpdi_pkg::OFS_CODE +: 8];
	assign param_index         =
		state_reg.cmd_img[8*fpdi_pkg::OFS_INDEX +: 16];
	assign param_value         =
		state_reg.cmd_img[8*fpdi_pkg::OFS_VALUE +: 32];
	assign setpoint32          =
		state_reg.cmd_img[8*fpdi_pkg::OFS_SP32 +: 32];
	assign setpoint16          =
		state_reg.cmd_img[8*fpdi_pkg::OFS_SP16 +: 16];
	assign op_select_field     =
		state_reg.cmd_img[8*fpdi_pkg::OFS_OPSEL +: 8];
	assign state_command_field =
		state_reg.cmd_img[8*fpdi_pkg::OFS_STCMD +: 8];
	assign accel_rate          =
		state_reg.cmd_img[8*fpdi_pkg::OFS_ACCEL +: 32];
	assign decel_rate          =
		state_reg.cmd_img[8*fpdi_pkg::OFS_DECEL +: 32];

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_sync_b);

	// checks
	a_poll_answered: assert property (
		cmd_done |=> tx_valid && !rx_ready)
		else $error("poll not answered");
	a_rsp_ends_last: assert property (
		$fell(tx_valid) |-> $past(tx_last && tx_ready))
		else $error("response ended early");
	a_reject_disabled: assert property (
		cmd_done && toggled && !op_enabled
		|=> state_reg.fault && !mode_start)
		else $error("mode started while not enabled");
	a_start_enabled: assert property (
		mode_start |-> $past(op_enabled) && $past(cmd_done))
		else $error("start without enable");
	a_echo_toggle: assert property (
		mode_start |-> state_reg.echo
		== op_select_field[fpdi_pkg::TOGGLE_BIT])
		else $error("toggle not echoed");
	a_end_low_run: assert property (
		state_reg.running |-> !state_reg.move_end)
		else $error("end flag high while running");
	a_end_sets: assert property (
		state_reg.running && move_done && !cmd_done
		|=> state_reg.move_end && !state_reg.running)
		else $error("end flag not set");
	a_rsv_zero: assert property (
		$rose(tx_valid) |-> state_reg.tx_img[
		fpdi_pkg::IMG_W-1:fpdi_pkg::CMD_W] == '0)
		else $error("reserved status bytes not zero");
	a_bus_wait: assert property (
		bus_acc && !state_reg.ack
		|-> avs_waitrequest ##1 !avs_waitrequest)
		else $error("bus wait not one cycle");
	a_rdata_hold: assert property (
		!avs_read |=> $stable(avs_readdata))
		else $error("read data changed without a read");

	// stream, field and toggle handshake checks
	a_fields_hold: assert property (
		!cmd_strobe |-> $stable(accel_rate) && $stable(decel_rate)
		&& $stable(setpoint32) && $stable(state_command_field))
		else $error("command fields changed without strobe");
	a_rx_stalled: assert property (
		tx_valid |-> !rx_ready)
		else $error("command accepted during response");
	a_tx_hold: assert property (
		tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
		else $error("response byte lost while stalled");
	a_edge_starts: assert property (
		cmd_done && toggled && op_enabled |=> mode_start)
		else $error("toggle edge did not start");
	a_fault_clear: assert property (
		mode_start |-> !state_reg.fault)
		else $error("fault left set on accepted start");

	c_start: cover property (mode_start);
	c_reject: cover property (cmd_done && toggled && !op_enabled);
	c_end: cover property (state_reg.running ##1 state_reg.move_end);
	c_frame: cover property (tx_last && tx_ready);
	c_bus_write: cover property (avs_write && !avs_waitrequest);

endmodule : fpdi_framer

/* File: verification/fpdi_master.sv */
// partner model: fieldbus master polling the image framer
module fpdi_master (
	input  wire logic       mclk,
	output logic            rx_valid,
	output logic            rx_sof,
	output logic [7:0]      rx_data,
	input  wire logic       rx_ready,
	input  wire logic       tx_valid,
	input  wire logic [7:0] tx_data,
	input  wire logic       tx_last,
	output logic            tx_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] cmd_img [40];
	logic [7:0] rsp_img [40];
	logic       last_ok;
	// idle lines at time zero
	initial begin
		rx_valid = 1'b0;
		rx_sof   = 1'b0;
		rx_data  = 8'h00;
		tx_ready = 1'b0;
	end
	// one poll command out, one poll response back
	task poll(output bit ok);
		int k;
		int n;
		@(posedge mclk);
		k = 0;
		n = 0;
		last_ok = 1'b1;
		// command image goes out as raw bytes, byte k at offset k
		while (k < 40 && n < 400) begin
			rx_valid <= 1'b1;
			rx_sof   <= (k == 0);
			rx_data  <= cmd_img[k];
			@(posedge mclk);
			n++;
			if (rx_ready === 1'b1) k++;
		end
		// released line shows no stale byte
		rx_valid <= 1'b0;
		rx_sof   <= 1'b0;
		rx_data  <= ~cmd_img[39];
		k = 0;
		// drain the response, stalling at random
		while (k < 40 && n < 1200) begin
			tx_ready <= 1'($urandom_range(0, 1));
			@(posedge mclk);
			n++;
			if (tx_valid === 1'b1 && tx_ready) begin
				rsp_img[k] = tx_data;
				if (tx_last !== (k == 39)) last_ok = 1'b0;
				k++;
			end
		end
		tx_ready <= 1'b0;
		ok = (k == 40);
	endtask : poll
endmodule : fpdi_master

/* File: verification/testbench.sv */
// self-checking bench for the process data image framer
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic         mclk, rst_b, avs_read, avs_write, avs_waitrequest;
	logic [4:0]   avs_address;
	logic [31:0]  avs_writedata, avs_readdata, q;
	logic         rx_valid, rx_sof, rx_ready, tx_valid, tx_last, tx_ready;
	logic [7:0]   rx_data, tx_data, prev_state, sub, code, opsel, stcmd;
	logic         cmd_strobe, mode_start, op_enabled, move_done;
	logic [15:0]  idx, sp16;
	logic [31:0]  pval, sp32, acc, dec;
	logic [167:0] sv;
	logic [191:0] cap, ec;
	logic [319:0] ex, got;
	bit           ok, tog, nt, fault, endf, run;
	int           n_fail, comparisons, n_strobe, n_start, starts, rej;

	// device under test
	fpdi_framer u_fpdi_framer (
		.mclk, .rst_b, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest,
		.rx_valid, .rx_sof, .rx_data, .rx_ready,
		.tx_valid, .tx_data, .tx_last, .tx_ready, .cmd_strobe,
		.param_subindex(sub), .param_command_code(code), .param_index(idx),
		.param_value(pval), .setpoint32(sp32), .setpoint16(sp16),
		.op_select_field(opsel), .state_command_field(stcmd),
		.accel_rate(acc), .decel_rate(dec), .mode_start,
		.rsp_subindex(sv[7:0]), .rsp_command_code(sv[15:8]),
		.rsp_index(sv[31:16]), .rsp_value(sv[63:32]),
		.capt1_count(sv[65:64]), .capt2_count(sv[67:66]),
		.motor_still(sv[68]), .motor_forward(sv[69]),
		.motor_backward(sv[70]), .within_deviation_window(sv[71]),
		.profile_still(sv[72]), .profile_slowing(sv[73]),
		.profile_speeding_up(sv[74]), .profile_cruising(sv[75]),
		.local_input_1(sv[76]), .local_input_2(sv[77]),
		.local_input_3(sv[78]), .local_input_4(sv[79]),
		.safe_torque_off_chan_a(sv[80]), .safe_torque_off_chan_b(sv[81]),
		.cur_mode(sv[87:82]), .cur_state(sv[103:88]),
		.actual_position(sv[135:104]), .actual_velocity(sv[167:136]),
		.op_enabled, .move_done
	);

	// far-side master
	fpdi_master u_fpdi_master (
		.mclk, .rx_valid, .rx_sof, .rx_data, .rx_ready,
		.tx_valid, .tx_data, .tx_last, .tx_ready
	);

	// 200 MHz clock
	always #2.5 mclk = ~mclk;

	// capture command fields and count pulses
	always @(posedge mclk) begin
		if (cmd_strobe === 1'b1) begin
			cap <= {dec, acc, stcmd, opsel, sp16, sp32, pval, idx, code, sub};
			n_strobe++;
		end
		if (mode_start === 1'b1) n_start++;
	end

	// compare and count
	task chk(input string what, input logic [319:0] e, input logic [319:0] g);
		comparisons++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", what, e, g);
		end
	endtask : chk

	// counts and verdict
	task results;
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : results

	// one avalon transfer, held until waitrequest is sampled low
	task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
		int n;
		@(posedge mclk);
		avs_address   <= a;
		avs_writedata <= d;
		avs_read      <= ~wr;
		avs_write     <= wr;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		q = avs_readdata;
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
		if (avs_waitrequest !== 1'b0) begin
			n_fail++;
			results();
		end
	endtask : bus

	// main sequence
	initial begin
		mclk = 1'b0;
		rst_b = 1'b0;
		avs_address = 5'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		op_enabled = 1'b0;
		move_done = 1'b0;
		sv = '0;
		prev_state = 8'h00;
		endf = 1'b1;
		void'($urandom(68));
		repeat (16) @(posedge mclk);
		rst_b <= 1'b1;
		repeat (3) @(posedge mclk);
		// identity codes and an unmapped place
		bus(1'b0, 5'h10, 32'h0);
		chk("assembly ids", 320'h7167, 320'(q));
		bus(1'b1, 5'h14, 32'hffffffff);
		bus(1'b0, 5'h14, 32'h0);
		chk("unmapped", 320'h0, 320'(q));
		$display("test registers done");
		for (int i = 0; i < 8; i++) begin
			for (int k = 0; k < 40; k++) u_fpdi_master.cmd_img[k] = 8'($urandom);
			nt = tog ^ (i % 3 != 2);
			u_fpdi_master.cmd_img[14][7] = nt;
			// state byte held while the mode toggles
			if (nt != tog) u_fpdi_master.cmd_img[15] = prev_state;
			prev_state = u_fpdi_master.cmd_img[15];
			op_enabled <= (i != 4);
			sv <= 168'({$urandom, $urandom, $urandom, $urandom, $urandom, $urandom});
			// reference model of the toggle handshake
			if (nt != tog && i != 4) begin
				run = 1'b1;
				endf = 1'b0;
				fault = 1'b0;
				starts++;
			end
			if (nt != tog && i == 4) begin
				fault = 1'b1;
				rej++;
			end
			tog = nt;
			u_fpdi_master.poll(ok);
			if (!ok) begin
				n_fail++;
				results();
			end
			for (int k = 0; k < 24; k++) ec[8*k+:8] = u_fpdi_master.cmd_img[k];
			chk("fields", 320'(ec), 320'(cap));
			chk("strobes", 320'(i + 1), 320'(n_strobe));
			chk("starts", 320'(starts), 320'(n_start));
			ex = '0;
			ex[67:0] = sv[67:0];
			ex[89:86] = sv[71:68];
			ex[94:91] = sv[75:72];
			ex[101:96] = sv[81:76];
			ex[109:104] = sv[87:82];
			ex[110] = fault;
			ex[111] = tog;
			ex[127:112] = sv[103:88];
			ex[126] = endf;
			ex[191:128] = sv[167:104];
			for (int k = 0; k < 40; k++) got[8*k+:8] = u_fpdi_master.rsp_img[k];
			chk("image", ex, got);
			chk("last", 320'h1, 320'(u_fpdi_master.last_ok));
			// finish the movement on odd polls
			if (i % 2 == 1) begin
				move_done <= 1'b1;
				@(posedge mclk);
				move_done <= 1'b0;
				if (run) endf = 1'b1;
				run = 1'b0;
			end
			bus(1'b0, 5'h04, 32'h0);
			chk("stat", 320'({endf, tog, fault, run}), 320'(q));
			$display("test poll %0d done", i);
		end
		bus(1'b0, 5'h08, 32'h0);
		chk("polls", 320'h8, 320'(q[15:0]));
		bus(1'b0, 5'h0c, 32'h0);
		chk("rejects", 320'(rej), 320'(q[15:0]));
		bus(1'b1, 5'h00, 32'h3);
		bus(1'b0, 5'h08, 32'h0);
		chk("cleared", 320'h0, 320'(q[15:0]));
		bus(1'b0, 5'h0c, 32'h0);
		chk("rejects cleared", 320'h0, 320'(q[15:0]));
		bus(1'b0, 5'h00, 32'h0);
		chk("enable on", 320'h1, 320'(q));
		$display("test counters done");
		// frames are consumed but dropped while disabled
		bus(1'b1, 5'h00, 32'h0);
		bus(1'b0, 5'h00, 32'h0);
		chk("enable off", 320'h0, 320'(q));
		u_fpdi_master.poll(ok);
		chk("dropped", 320'h0, 320'(ok));
		chk("strobes off", 320'h8, 320'(n_strobe));
		chk("starts off", 320'(starts), 320'(n_start));
		bus(1'b0, 5'h08, 32'h0);
		chk("polls off", 320'h0, 320'(q[15:0]));
		$display("test disable done");
		results();
	end
endmodule : testbench
